// ===== bench/ir_carrier_measure_and_fsm_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ir_carrier_measure_and_fsm_status_tb;
    import ir_codec_pkg::*;
    logic clk, nrst, ce, go, env, car, tx, cnt_rdy;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs, ws;
    logic [15:0] edges, txw;
    logic [7:0] rd;
    logic [11:0] per [4];
    int n_mismatch, num_checks, p;

    ir_codec u_dut (.CLK(clk), .NRST(nrst), .CE(ce),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .RX_ENVELOPE(env), .RX_CARRIER(car), .TX_OUT(tx), .COUNT_READY(cnt_rdy));

    ir_link_model u_link (.clk(clk), .go(go), .edges(edges), .tx_out(tx),
        .rx_envelope(env), .rx_carrier(car), .tx_width(txw));

    always #20 clk = ~clk;

    task automatic conclude();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic fail(input string m);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : fail

    task automatic chk_eq(input logic [7:0] got, input logic [7:0] exp, input string m);
        num_checks++;
        if (got !== exp) fail(m);
    endtask : chk_eq

    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi, input string m);
        num_checks++;
        if ($isunknown(got) || got < lo || got > hi) fail(m);
    endtask : chk_rng

    // bready and rready stay high, so the answer is taken at the edge it shows
    task automatic axi_wr(input logic [4:0] idx, input logic [7:0] d);
        int n;
        logic done;
        @(posedge clk);
        awaddr <= {25'h0, idx, 2'h0};
        wdata <= {24'h00_0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        done = 1'h0;
        for (n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            done = (bvalid === 1'h1);
            ws = bresp;
        end
        if (!done) begin
            fail("write answer missing");
            conclude();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [4:0] idx, output logic [7:0] d, output logic [1:0] r);
        int n;
        logic done;
        @(posedge clk);
        araddr <= {25'h0, idx, 2'h0};
        arvalid <= 1'h1;
        done = 1'h0;
        for (n = 0; n < 100 && !done; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'h0;
            done = (rvalid === 1'h1);
            d = rdata[7:0];
            r = rresp;
        end
        if (!done) begin
            fail("read answer missing");
            conclude();
        end
    endtask : axi_rd

    // which: 0 count ready pulse, 1 transmit high, 2 transmit low
    task automatic wait_for(input int which, input int lim);
        int n;
        logic hit;
        hit = 1'h0;
        for (n = 0; n < lim && !hit; n++) begin
            @(posedge clk);
            hit = (which == 0) ? (cnt_rdy === 1'h1) : (tx === (which == 1));
        end
        if (!hit) begin
            fail("wait timed out");
            conclude();
        end
    endtask : wait_for

    task automatic burst(input logic [15:0] n);
        @(posedge clk);
        edges <= n;
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
    endtask : burst

    initial begin
        clk = 1'h0;
        nrst = 1'h0;
        ce = 1'h1;
        go = 1'h0;
        edges = 16'h0000;
        awaddr = 32'h0000_0000;
        wdata = 32'h0000_0000;
        araddr = 32'h0000_0000;
        wstrb = 4'hF;
        awvalid = 1'h0;
        wvalid = 1'h0;
        arvalid = 1'h0;
        bready = 1'h1;
        rready = 1'h1;
        n_mismatch = 0;
        num_checks = 0;
        per = '{PERIOD_CYC_0, PERIOD_CYC_1, PERIOD_CYC_2, PERIOD_CYC_3};
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        repeat (2) @(posedge clk);
        axi_rd(IDX_VIEW_THRESH, rd, rs);
        chk_eq(rd, 8'h14, "idle view");
        axi_rd(5'h1F, rd, rs);
        chk_eq({6'h00, rs}, {6'h00, RESP_SLVERR}, "unmapped read answer");
        axi_wr(5'h1F, 8'h00);
        chk_eq({6'h00, ws}, {6'h00, RESP_SLVERR}, "unmapped write answer");
        axi_wr(IDX_VIEW_THRESH, 8'h40);
        chk_eq({6'h00, ws}, {6'h00, RESP_OKAY}, "threshold write answer");
        axi_rd(IDX_VIEW_THRESH, rd, rs);
        chk_eq(rd, 8'h14, "view hidden by threshold");
        axi_wr(IDX_CTRL, 8'h10);
        burst(16'h012C);
        // lands well inside the burst, only to place the read
        repeat (100) @(posedge clk);
        axi_rd(IDX_VIEW_THRESH, rd, rs);
        chk_eq(rd, 8'h24, "receiving view");
        wait_for(0, 8000);
        axi_rd(IDX_EDGE_UPPER, rd, rs);
        chk_eq(rd, 8'h01, "edge count upper");
        axi_rd(IDX_EDGE_LOWER, rd, rs);
        chk_eq(rd, 8'h2C, "edge count lower");
        axi_rd(IDX_STATUS, rd, rs);
        chk_eq(rd & 8'h08, 8'h08, "short burst flag");
        axi_rd(IDX_ENV_LOWER, rd, rs);
        chk_rng({8'h00, rd}, 47, 49, "envelope time");
        axi_wr(IDX_EDGE_UPPER, 8'hFF);
        axi_rd(IDX_EDGE_UPPER, rd, rs);
        chk_eq(rd, 8'h01, "upper byte written");
        axi_wr(IDX_STATUS, 8'h08);
        axi_wr(IDX_VIEW_THRESH, 8'h02);
        burst(16'h0064);
        wait_for(0, 8000);
        axi_rd(IDX_EDGE_LOWER, rd, rs);
        chk_eq(rd, 8'h64, "second count lower");
        axi_rd(IDX_EDGE_UPPER, rd, rs);
        chk_eq(rd, 8'h00, "second count upper");
        axi_rd(IDX_STATUS, rd, rs);
        chk_eq(rd & 8'h08, 8'h00, "long burst flag");
        for (p = 0; p < 4; p++) begin
            axi_wr(IDX_CTRL, 8'(p));
            axi_wr(IDX_TX_ENTRY, 8'h83);
            wait_for(1, 100);
            axi_rd(IDX_VIEW_THRESH, rd, rs);
            chk_eq(rd, 8'h11, "transmit high view");
            wait_for(2, 12000);
            chk_rng(txw, 2 * int'(per[p]) + 1, 4 * int'(per[p]), "pulse width");
        end
        axi_wr(IDX_CTRL, 8'h00);
        axi_wr(IDX_TX_ENTRY, 8'h05);
        // skip past the entry read step, only to place the read
        repeat (4) @(posedge clk);
        axi_rd(IDX_VIEW_THRESH, rd, rs);
        chk_eq(rd, 8'h10, "transmit low view");
        chk_eq({7'h00, tx}, 8'h00, "low level driven");
        conclude();
    end
endmodule : ir_carrier_measure_and_fsm_status_tb
`default_nettype wire

// ===== bench/ir_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module ir_link_model (
    // clock
    input wire logic clk,
    // burst request
    input wire logic go,
    input wire logic [15:0] edges,
    // link pins
    input wire logic tx_out,
    output logic rx_envelope,
    output logic rx_carrier,
    // width of the last transmit pulse
    output logic [15:0] tx_width
);
    logic tx_prev;
    initial begin
        rx_envelope = 1'h0;
        rx_carrier = 1'h0;
        tx_width = 16'h0000;
        tx_prev = 1'h0;
    end
    // carrier stands low outside a burst, as a real receiver output does
    always begin
        @(posedge go);
        @(posedge clk);
        rx_envelope <= 1'h1;
        repeat (edges) begin
            @(posedge clk);
            rx_carrier <= 1'h1;
            repeat (2) @(posedge clk);
            rx_carrier <= 1'h0;
            @(posedge clk);
        end
        @(posedge clk);
        rx_envelope <= 1'h0;
    end
    always @(posedge clk) begin
        tx_prev <= tx_out;
        if (tx_out && !tx_prev) tx_width <= 16'h0001;
        else if (tx_out) tx_width <= tx_width + 16'h0001;
    end
endmodule : ir_link_model
`default_nettype wire

// ===== logic/ir_codec.sv
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ir_codec
    import ir_codec_pkg::*;
(
    // clock, reset, enable
    input wire logic CLK,
    input wire logic NRST,
    input wire logic CE,
    // axi4-lite write
    input wire logic [31:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    // axi4-lite read
    input wire logic [31:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    // infrared link
    input wire logic RX_ENVELOPE,
    input wire logic RX_CARRIER,
    output logic TX_OUT,
    output logic COUNT_READY
);
    import ir_codec_pkg::*;

    logic aw_have_q, w_have_q, aw_ok_q, w_lane_q;
    logic [4:0] aw_idx_q;
    logic [7:0] w_data_q;
    logic [7:0] ctrl_q, thresh_q, entry_q, view_q, edge_upper_q, edge_lower_q;
    logic short_flag_q, entry_pend_q, env_q, carrier_q;
    logic [6:0] dur_q, dur_cnt_q;
    logic [15:0] edge_cnt, env_time;
    logic [7:0] burst_len, low_len;
    logic tick;
    dec_state_t dec_q;
    enc_state_t enc_q;

    function automatic logic idx_ok(input logic [31:0] a);
        logic [4:0] i;
        i = a[6:2];
        idx_ok = (a[31:7] == 25'h0) && (i == IDX_CTRL || i == IDX_STATUS
            || i == IDX_EDGE_UPPER || i == IDX_EDGE_LOWER || i == IDX_VIEW_THRESH
            || i == IDX_TX_ENTRY || i == IDX_ENV_LOWER || i == IDX_ENV_UPPER);
    endfunction : idx_ok

    wire aw_take = AWVALID && AWREADY;
    wire w_take = WVALID && WREADY;
    wire do_wr = aw_have_q && w_have_q && !BVALID;
    wire wr_en = do_wr && aw_ok_q && w_lane_q;
    wire ar_take = ARVALID && ARREADY;

    // write channel: address and data in either order
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            aw_have_q <= 1'b0;
            aw_ok_q <= 1'b0;
            aw_idx_q <= 5'h00;
            AWREADY <= 1'b0;
        end else if (CE) begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_ok_q <= idx_ok(AWADDR);
                aw_idx_q <= AWADDR[6:2];
                AWREADY <= 1'b0;
            end else if (do_wr) begin
                aw_have_q <= 1'b0;
            end else if (!aw_have_q && !BVALID) begin
                AWREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            w_have_q <= 1'b0;
            w_lane_q <= 1'b0;
            w_data_q <= 8'h00;
            WREADY <= 1'b0;
        end else if (CE) begin
            if (w_take) begin
                w_have_q <= 1'b1;
                w_lane_q <= WSTRB[0];
                w_data_q <= WDATA[7:0];
                WREADY <= 1'b0;
            end else if (do_wr) begin
                w_have_q <= 1'b0;
            end else if (!w_have_q && !BVALID) begin
                WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else if (CE) begin
            if (do_wr) begin
                BVALID <= 1'b1;
                BRESP <= aw_ok_q ? RESP_OKAY : RESP_SLVERR;
            end else if (BREADY) begin
                BVALID <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= RESP_OKAY;
        end else if (CE) begin
            if (ar_take) begin
                ARREADY <= 1'b0;
                RVALID <= 1'b1;
                RRESP <= idx_ok(ARADDR) ? RESP_OKAY : RESP_SLVERR;
                case (ARADDR[31:2])
                    30'(IDX_CTRL): RDATA <= {24'h00_0000, ctrl_q};
                    30'(IDX_STATUS): RDATA <= 32'(short_flag_q) << STATUS_SHORT_BIT;
                    30'(IDX_EDGE_UPPER): RDATA <= {24'h00_0000, edge_upper_q};
                    30'(IDX_EDGE_LOWER): RDATA <= {24'h00_0000, edge_lower_q};
                    30'(IDX_VIEW_THRESH): RDATA <= {24'h00_0000, view_q};
                    30'(IDX_TX_ENTRY): RDATA <= {24'h00_0000, entry_q};
                    30'(IDX_ENV_LOWER): RDATA <= {24'h00_0000, env_time[7:0]};
                    30'(IDX_ENV_UPPER): RDATA <= {24'h00_0000, env_time[15:8]};
                    default: RDATA <= 32'h0000_0000;
                endcase
            end else if (RVALID && RREADY) begin
                RVALID <= 1'b0;
            end else if (!RVALID) begin
                ARREADY <= 1'b1;
            end
        end
    end

    // software registers
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_q <= CTRL_RESET;
            thresh_q <= THRESH_RESET;
        end else if (CE && wr_en) begin
            if (aw_idx_q == IDX_CTRL) begin
                ctrl_q <= w_data_q;
            end
            if (aw_idx_q == IDX_VIEW_THRESH) begin
                thresh_q <= w_data_q;
            end
        end
    end

    wire rx_start = dec_q == DEC_WAIT_H && ctrl_q[CTRL_RXEN_BIT] && RX_ENVELOPE;
    wire in_rx = dec_q == DEC_CONT;
    wire env_fall = in_rx && env_q && !RX_ENVELOPE;
    wire burst_short = env_fall && burst_len < thresh_q;
    wire rx_timeout = in_rx && !RX_ENVELOPE && low_len >= RX_TIMEOUT_PERIODS;

    sample_tick_gen u_tick (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .sel(ctrl_q[1:0]),
        .tick(tick)
    );

    sat_counter #(.W(16)) u_edges (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .clr(rx_start),
        .inc(in_rx && RX_CARRIER && !carrier_q),
        .count(edge_cnt)
    );

    sat_counter #(.W(16)) u_env_time (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .clr(rx_start),
        .inc(in_rx && RX_ENVELOPE && tick),
        .count(env_time)
    );

    sat_counter #(.W(8)) u_burst (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .clr(rx_start || env_fall),
        .inc(in_rx && RX_ENVELOPE && tick),
        .count(burst_len)
    );

    sat_counter #(.W(8)) u_low (
        .clk(CLK),
        .nrst(NRST),
        .ce(CE),
        .clr(!in_rx || RX_ENVELOPE),
        .inc(tick),
        .count(low_len)
    );

    // decoder
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            dec_q <= DEC_WAIT_H;
            env_q <= 1'b0;
            carrier_q <= 1'b0;
            edge_upper_q <= 8'h00;
            edge_lower_q <= 8'h00;
            COUNT_READY <= 1'b0;
        end else if (CE) begin
            env_q <= RX_ENVELOPE;
            carrier_q <= RX_CARRIER;
            COUNT_READY <= rx_timeout;
            case (dec_q)
                DEC_WAIT_H: if (rx_start) dec_q <= DEC_CONT;
                DEC_CONT: if (rx_timeout) begin
                    dec_q <= DEC_OVER;
                    edge_upper_q <= edge_cnt[15:8];
                    edge_lower_q <= edge_cnt[7:0];
                end
                DEC_OVER: dec_q <= DEC_WAIT_H;
                default: dec_q <= DEC_WAIT_H;
            endcase
        end
    end

    // short-burst flag, a new short burst beats a clear in the same cycle
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            short_flag_q <= 1'b0;
        end else if (CE) begin
            if (burst_short) begin
                short_flag_q <= 1'b1;
            end else if (wr_en && aw_idx_q == IDX_STATUS && w_data_q[STATUS_SHORT_BIT]) begin
                short_flag_q <= 1'b0;
            end
        end
    end

    // encoder: one pending entry, no queue
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            enc_q <= ENC_IDLE;
            entry_q <= 8'h00;
            entry_pend_q <= 1'b0;
            dur_q <= 7'h00;
            dur_cnt_q <= 7'h00;
            TX_OUT <= 1'b0;
        end else if (CE) begin
            if (wr_en && aw_idx_q == IDX_TX_ENTRY) begin
                entry_q <= w_data_q;
                // landing as the idle encoder takes the entry: it is taken now, not sent twice
                entry_pend_q <= !(enc_q == ENC_IDLE && entry_pend_q);
            end else if (enc_q == ENC_IDLE && entry_pend_q) begin
                entry_pend_q <= 1'b0;
            end
            case (enc_q)
                ENC_IDLE: if (entry_pend_q) enc_q <= ENC_READ;
                ENC_READ: begin
                    TX_OUT <= entry_q[ENTRY_LEVEL_BIT];
                    dur_q <= entry_q[6:0];
                    dur_cnt_q <= 7'h00;
                    enc_q <= ENC_LEVEL;
                end
                ENC_LEVEL: begin
                    if (dur_cnt_q >= dur_q) begin
                        enc_q <= ENC_IDLE;
                        TX_OUT <= 1'b0;
                    end else if (tick) begin
                        dur_cnt_q <= dur_cnt_q + 7'h01;
                    end
                end
                default: enc_q <= ENC_IDLE;
            endcase
        end
    end

    // state view, registered so it is zero through reset
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            view_q <= VIEW_RESET;
        end else if (CE) begin
            view_q <= 8'h00;
            view_q[VIEW_DEC_OVER] <= dec_q == DEC_OVER;
            view_q[VIEW_DEC_CONT] <= dec_q == DEC_CONT;
            view_q[VIEW_DEC_WAIT] <= dec_q == DEC_WAIT_H;
            view_q[VIEW_ENC_IDLE] <= enc_q == ENC_IDLE;
            view_q[VIEW_ENC_READ] <= enc_q == ENC_READ;
            view_q[VIEW_ENC_LEVEL] <= TX_OUT;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_entry_load;
        CE && enc_q == ENC_READ;
    endsequence
    sequence s_rx_end;
        CE && rx_timeout;
    endsequence

    a_entry_level_out: assert property (s_entry_load |=> TX_OUT == $past(entry_q[7])
        && dur_q == $past(entry_q[6:0]))
        else $error("entry level or length not loaded");
    a_count_capture: assert property (s_rx_end |=> dec_q == DEC_OVER
        && {edge_upper_q, edge_lower_q} == $past(edge_cnt))
        else $error("edge count not captured at time-out");
    a_count_full: assert property (dec_q == DEC_OVER |->
        16'(edge_upper_q) * 16'd256 + 16'(edge_lower_q) == edge_cnt)
        else $error("full count does not match edge counter");
    a_ready_unasked: assert property (s_rx_end |=> COUNT_READY ##1 !COUNT_READY [*2])
        else $error("ready pulse missing or too long");
    a_view_reserved: assert property ((view_q & VIEW_RESERVED_MASK) == 8'h00)
        else $error("reserved view bits set");
    a_view_wait: assert property (CE |=> view_q[VIEW_DEC_WAIT]
        == ($past(dec_q) == DEC_WAIT_H))
        else $error("decoder wait bit wrong");
    a_view_enc_idle: assert property (CE |=> view_q[VIEW_ENC_IDLE]
        == ($past(enc_q) == ENC_IDLE))
        else $error("encoder idle bit wrong");
    a_thresh_write: assert property (CE && wr_en && aw_idx_q == IDX_VIEW_THRESH
        |=> thresh_q == $past(w_data_q))
        else $error("threshold not written");
    a_short_flag: assert property (CE && burst_short |=> short_flag_q)
        else $error("short burst not flagged");
    a_start_clear: assert property (CE && rx_start |=> edge_cnt == 16'h0000
        && env_time == 16'h0000)
        else $error("counters not cleared at start");
endmodule : ir_codec
`default_nettype wire

// ===== logic/ir_codec_pkg.sv
// How it works
// - a transmit entry carries the output level in bit 7 and its length in sample periods in bits 6..0.
// - the upper byte of the carrier rising-edge count caught at receive time-out reads at index D.
// - the lower byte of that same caught count reads at index E.
// - the full carrier count is the upper byte times 256 plus the lower byte.
// - the count is published at time-out on its own, with a ready pulse and no request needed.
// - the receiver totals the time the envelope is high so software can divide count by time.
// - the state view at index F is read-only, bits 7 and 3 read zero, and it resets to zero.
// - view bit 4 is 1 while the decoder waits for a high level and 0 while receiving.
// - view bit 2 is 1 while the encoder is idle and 0 while transmitting.
// - view bit 0 is the driven level, bit 1 the entry read state, bits 6 and 5 decoder over and continuing.
// - writes at index F land in a write-only threshold that resets to zero; reads there give the view.
// - the threshold is the shortest expected burst length in sample periods.
// - a two-bit select picks the sample period: 1 us, 25 us, 50 us or 100 us.
// - a burst shorter than the threshold sets the short-burst flag; a longer one leaves it clear.
package ir_codec_pkg;
    localparam int CLK_MHZ = 25;
    localparam int PERIOD_US_0 = 1;
    localparam int PERIOD_US_1 = 25;
    localparam int PERIOD_US_2 = 50;
    localparam int PERIOD_US_3 = 100;
    localparam logic [11:0] PERIOD_CYC_0 = 12'(PERIOD_US_0 * CLK_MHZ);
    localparam logic [11:0] PERIOD_CYC_1 = 12'(PERIOD_US_1 * CLK_MHZ);
    localparam logic [11:0] PERIOD_CYC_2 = 12'(PERIOD_US_2 * CLK_MHZ);
    localparam logic [11:0] PERIOD_CYC_3 = 12'(PERIOD_US_3 * CLK_MHZ);
    // envelope-low periods that end a reception
    localparam logic [7:0] RX_TIMEOUT_PERIODS = 8'h08;
    // register indices, byte address is four times the index
    localparam logic [4:0] IDX_CTRL = 5'h00;
    localparam logic [4:0] IDX_STATUS = 5'h01;
    localparam logic [4:0] IDX_EDGE_UPPER = 5'h0D;
    localparam logic [4:0] IDX_EDGE_LOWER = 5'h0E;
    localparam logic [4:0] IDX_VIEW_THRESH = 5'h0F;
    localparam logic [4:0] IDX_TX_ENTRY = 5'h10;
    localparam logic [4:0] IDX_ENV_LOWER = 5'h11;
    localparam logic [4:0] IDX_ENV_UPPER = 5'h12;
    // field positions
    localparam int ENTRY_LEVEL_BIT = 7;
    localparam int CTRL_RXEN_BIT = 4;
    localparam int STATUS_SHORT_BIT = 3;
    localparam int VIEW_DEC_OVER = 6;
    localparam int VIEW_DEC_CONT = 5;
    localparam int VIEW_DEC_WAIT = 4;
    localparam int VIEW_ENC_IDLE = 2;
    localparam int VIEW_ENC_READ = 1;
    localparam int VIEW_ENC_LEVEL = 0;
    localparam logic [7:0] VIEW_RESERVED_MASK = 8'h88;
    // reset values, then bus response codes
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] VIEW_RESET = 8'h00;
    localparam logic [7:0] THRESH_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        DEC_WAIT_H = 3'h1,
        DEC_CONT = 3'h2,
        DEC_OVER = 3'h4
    } dec_state_t;
    typedef enum logic [2:0] {
        ENC_IDLE = 3'h1,
        ENC_READ = 3'h2,
        ENC_LEVEL = 3'h4
    } enc_state_t;
endpackage : ir_codec_pkg

// ===== logic/sample_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none
module sample_tick_gen
    import ir_codec_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [1:0] sel,
    output logic tick
);
    logic [11:0] cnt_q;
    logic [11:0] limit;

    always_comb begin
        case (sel)
            2'h0: limit = PERIOD_CYC_0;
            2'h1: limit = PERIOD_CYC_1;
            2'h2: limit = PERIOD_CYC_2;
            default: limit = PERIOD_CYC_3;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 12'h000;
            tick <= 1'b0;
        end else if (ce) begin
            // a period change just shortens or stretches the current period
            if (cnt_q + 12'h001 >= limit) begin
                cnt_q <= 12'h000;
                tick <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 12'h001;
                tick <= 1'b0;
            end
        end
    end
endmodule : sample_tick_gen
`default_nettype wire

// ===== logic/sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
module sat_counter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic clr,
    input wire logic inc,
    output logic [W-1:0] count
);
    // saturates rather than wraps, so an overlong burst still reads large
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else if (ce) begin
            if (clr) begin
                count <= '0;
            end else if (inc && count != {W{1'b1}}) begin
                count <= count + 1'b1;
            end
        end
    end
endmodule : sat_counter
`default_nettype wire
